// ---- ir_key_led_model.sv ----
// key matrix and indicator wiring seen from the device pins
`timescale 1ns/10ps
module ir_key_led_model (
   input  wire logic                    clk_in,          // oscillator
   input  wire logic [3:0]              press_in,        // keys held
   input  wire ir_timer_pkg::pulldown_t pd_in,           // pull-downs
   input  wire logic                    ind_drv_in,      // indicator data
   input  wire logic                    ind_oe_in,       // indicator oe
   output logic      [3:0]              key_in_port_out, // key pins
   output logic                         sense_input_out, // sense pin
   output logic                         sense_ind_out    // indicator wire
);
   // ==================================================================
   // pin levels
   logic alt_r = 1'b0;
   // a pin with no pull-down and no driver wanders instead of holding
   always_ff @(posedge clk_in) begin
      alt_r <= ~alt_r;
   end
   assign key_in_port_out = press_in
                            | (pd_in.key_in_port_pd ? 4'h0 : {4{alt_r}});
   assign sense_input_out = pd_in.sense_input_pd ? 1'b0 : alt_r;
   assign sense_ind_out   = ind_oe_in ? ind_drv_in
                            : (pd_in.sense_indicator_pd ? 1'b0 : alt_r);
endmodule : ir_key_led_model

// ---- ir_remote_timer_standby.sv ----
// remote transmission timer, carrier gating, pin modes and standby
`timescale 1ns/10ps
module ir_remote_timer_standby (
   input  wire logic                       clk_in,          // oscillator
   input  wire logic                       arst_n_in,       // async reset
   input  wire logic                       pm_wr_in,        // mode write
   input  wire logic [7:0]                 pm_wdata_in,     // mode data
   output logic      [7:0]                 pm_rdata_out,    // mode readback
   input  wire logic                       tw_wr_in,        // timer write
   input  wire logic [9:0]                 tw_wdata_in,     // timer word
   output logic      [9:0]                 tw_rdata_out,    // timer word
   input  wire ir_timer_pkg::carrier_cfg_t car_cfg_in,      // carrier ctl
   input  wire logic                       halt_in,         // halt instr
   input  wire logic [3:0]                 halt_op_in,      // halt operand
   input  wire logic                       flag_clr_in,     // flag clear
   output logic                            flag_out,        // status flag
   input  wire logic [3:0]                 key_in_port_in,  // key inputs
   input  wire logic                       sense_input_in,  // sense pin
   input  wire logic                       sense_ind_in,    // indicator pin
   output logic                            sense_ind_out,   // indicator drv
   output logic                            sense_ind_oe_out,// indicator oe
   output logic                            sense_in_en_out, // sense enable
   output logic                            key_scan_oe_out, // key port oe
   output ir_timer_pkg::pulldown_t         pulldown_out,    // pull-downs
   output logic                            ir_drive_pin_out,// remote pin
   output logic                            timer_end_out,   // end of count
   output logic                            cpu_halt_out,    // cpu stopped
   output logic                            osc_stop_out     // osc stopped
);

   // ==================================================================
   // reset release and input synchronisers
   logic       rst_s1_r;
   logic       rst_n;
   logic [5:0] in_s1_r;
   logic [5:0] in_s2_r;

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rst_s1_r <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n    <= rst_s1_r;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         in_s1_r <= 6'h00;
         in_s2_r <= 6'h00;
      end else begin
         in_s1_r <= {sense_ind_in, sense_input_in, key_in_port_in};
         in_s2_r <= in_s1_r;
      end
   end

   wire [3:0] key_s   = in_s2_r[3:0];
   wire       sense_s = in_s2_r[4];
   wire       ind_s   = in_s2_r[5];

   // ==================================================================
   // pin mode register
   logic [7:0] pin_mode_bank_r;
   wire  [7:0] pin_mode_nxt = pm_wdata_in & ir_timer_pkg::PIN_MODE_WMASK;

   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n)
         pin_mode_bank_r <= ir_timer_pkg::PIN_MODE_RST;
      else if (pm_wr_in)
         pin_mode_bank_r <= pin_mode_nxt;
   end

   wire sense_in_mode = pin_mode_bank_r[ir_timer_pkg::PM_SENSE_IN];
   wire key_dir_out   = pin_mode_bank_r[ir_timer_pkg::PM_KEY_DIR];
   wire ind_mode      = pin_mode_bank_r[ir_timer_pkg::PM_IND_MODE];
   wire sense_pd_en   = pin_mode_bank_r[ir_timer_pkg::PM_SENSE_PD];
   wire key_pd_en     = pin_mode_bank_r[ir_timer_pkg::PM_KEY_PD];

   assign pm_rdata_out    = pin_mode_bank_r;
   assign sense_in_en_out = sense_in_mode;
   assign key_scan_oe_out = key_dir_out;
   assign sense_ind_oe_out = ind_mode;
   assign pulldown_out.sense_input_pd     = sense_pd_en & sense_in_mode;
   assign pulldown_out.sense_indicator_pd = sense_pd_en & ~ind_mode;
   assign pulldown_out.key_in_port_pd     = key_pd_en;

   // ==================================================================
   // timer: prescaler, down counter, enable flag
   ir_timer_pkg::standby_t state_r;

   logic [8:0] count_r;
   logic       drive_en_r;
   logic       running_r;
   logic [6:0] pre_r;

   wire [6:0] tick_last = car_cfg_in.clock_halver ?
                          ir_timer_pkg::TICK_LAST_HALF :
                          ir_timer_pkg::TICK_LAST_BASE;
   wire       tick      = (pre_r >= tick_last);
   wire       load      = tw_wr_in && (state_r == ir_timer_pkg::ST_RUN);
   wire       load_run  = (tw_wdata_in[8:0] != 9'h000);
   wire       stop_now  = (state_r == ir_timer_pkg::ST_STOP);
   wire [6:0] pre_nxt   = (load || tick) ? 7'h00 : pre_r + 7'h01;

   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n)
         pre_r <= 7'h00;
      else
         pre_r <= pre_nxt;
   end

   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         count_r    <= 9'h000;
         drive_en_r <= 1'b0;
         running_r  <= 1'b0;
      end else if (stop_now) begin
         count_r    <= 9'h000;
         drive_en_r <= 1'b0;
         running_r  <= 1'b0;
      end else if (load) begin
         count_r    <= tw_wdata_in[8:0];
         drive_en_r <= tw_wdata_in[9];
         running_r  <= load_run;
      end else if (running_r && tick) begin
         if (count_r == 9'h000)
            running_r <= 1'b0;
         else
            count_r <= count_r - 9'h001;
      end
   end

   assign tw_rdata_out  = {drive_en_r, count_r};
   assign timer_end_out = ~running_r;

   // ==================================================================
   // carrier generator and output synchroniser
   logic [7:0] car_cnt_r;
   logic       rem_r;
   logic       ind_r;

   wire [1:0] car_sel  = {car_cfg_in.carrier_sel_high,
                          car_cfg_in.carrier_sel_low};
   wire [7:0] car_base = (car_sel == 2'b00) ? ir_timer_pkg::CAR_PER_FAST :
                         (car_sel == 2'b01) ? ir_timer_pkg::CAR_PER_MID :
                                              ir_timer_pkg::CAR_PER_SLOW;
   wire [7:0] hi_base  = (car_sel == 2'b11) ? ir_timer_pkg::CAR_HI_THIRD :
                                              {1'b0, car_base[7:1]};
   wire [7:0] car_per  = car_cfg_in.clock_halver ?
                         {car_base[6:0], 1'b0} : car_base;
   wire [7:0] car_hi   = car_cfg_in.clock_halver ?
                         {hi_base[6:0], 1'b0} : hi_base;
   wire       car_wrap = (car_cnt_r >= car_per - 8'h01);
   wire [7:0] car_nxt  = car_wrap ? 8'h00 : car_cnt_r + 8'h01;
   wire       car_lvl  = (car_cnt_r < car_hi);
   wire       car_on   = ~car_cfg_in.carrier_gate;

   // free-running carrier: the first high pulse after a start may be cut
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n)
         car_cnt_r <= 8'h00;
      else
         car_cnt_r <= car_nxt;
   end

   wire run_drive = drive_en_r & running_r;
   wire rem_nxt   = run_drive ? (car_on ? car_lvl : 1'b1) :
                    (drive_en_r & car_on & rem_r & car_lvl);
   wire ind_nxt   = ~run_drive;

   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         rem_r <= 1'b0;
         ind_r <= 1'b1;
      end else begin
         rem_r <= rem_nxt;
         ind_r <= ind_nxt;
      end
   end

   assign ir_drive_pin_out = rem_r;
   assign sense_ind_out    = ind_r;

   // ==================================================================
   // standby control and status flag
   logic flag_r;
   logic stop_sense_r;

   wire op_halt     = (halt_op_in[2:0] == ir_timer_pkg::HALT_TIMER_OP);
   wire op_stop     = (halt_op_in[2:0] == ir_timer_pkg::STOP_ALL_OP) ||
                      (halt_op_in[2:0] == ir_timer_pkg::STOP_ALT_OP) ||
                      (halt_op_in[2:0] == ir_timer_pkg::STOP_ONE_OP);
   wire sense_hit   = (sense_in_mode & sense_s) | (~ind_mode & ind_s);
   wire key_hit     = |key_s;
   wire rel_req     = op_halt ? ~running_r :
                      (key_hit | (halt_op_in[3] & sense_hit));
   wire rel_stop    = key_hit | (stop_sense_r & sense_hit);
   wire in_run      = (state_r == ir_timer_pkg::ST_RUN);
   wire halt_take   = in_run && halt_in && (op_halt || op_stop);
   wire enter       = halt_take && !flag_r && !rel_req;
   wire wake_halt   = (state_r == ir_timer_pkg::ST_HALT) && ~running_r;
   wire wake_stop   = (state_r == ir_timer_pkg::ST_STOP) && rel_stop;
   wire flag_set    = wake_halt || wake_stop ||
                      (halt_take && rel_req);
   wire flag_drop   = flag_clr_in || (halt_take && flag_r && !rel_req);

   ir_timer_pkg::standby_t state_nxt;
   assign state_nxt = enter ? (op_halt ? ir_timer_pkg::ST_HALT :
                                         ir_timer_pkg::ST_STOP) :
                      (wake_halt || wake_stop) ? ir_timer_pkg::ST_RUN :
                      state_r;

   // standby touches no port register: the mode bank above keeps its
   // value and only a reset or a mode write changes it
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         state_r      <= ir_timer_pkg::ST_RUN;
         flag_r       <= 1'b0;
         stop_sense_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         if (flag_set)
            flag_r <= 1'b1;
         else if (flag_drop)
            flag_r <= 1'b0;
         if (enter)
            stop_sense_r <= halt_op_in[3];
      end
   end

   assign flag_out     = flag_r;
   assign cpu_halt_out = ~in_run;
   assign osc_stop_out = (state_r == ir_timer_pkg::ST_STOP);

   // ==================================================================
   // assertions
   a_fixed_bits_zero: assert property (@(posedge clk_in) disable iff (!rst_n)
      pm_wr_in |=> (pin_mode_bank_r[7:6] == 2'b00) && !pin_mode_bank_r[3])
      else $error("fixed mode bits not zero");

   a_load_starts: assert property (@(posedge clk_in) disable iff (!rst_n)
      load && load_run |=> running_r && (count_r == $past(tw_wdata_in[8:0])))
      else $error("nonzero timer write did not start");

   a_count_holds: assert property (@(posedge clk_in) disable iff (!rst_n)
      running_r && !tick && !tw_wr_in && !stop_now |=> $stable(count_r))
      else $error("counter moved between ticks");

   a_zero_stops: assert property (@(posedge clk_in) disable iff (!rst_n)
      running_r && tick && (count_r == 9'h000) && !tw_wr_in && !stop_now
      |=> !running_r && timer_end_out)
      else $error("timer did not stop at zero");

   a_indicator_run: assert property (@(posedge clk_in) disable iff (!rst_n)
      drive_en_r && running_r |=> !sense_ind_out)
      else $error("indicator not low while running");

   a_carrier_tail: assert property (@(posedge clk_in) disable iff (!rst_n)
      rem_r && car_lvl && car_on && drive_en_r && !stop_now && !tw_wr_in
      |=> ir_drive_pin_out)
      else $error("drive pin dropped inside a carrier high");

   a_halt_wake: assert property (@(posedge clk_in) disable iff (!rst_n)
      (state_r == ir_timer_pkg::ST_HALT) && !running_r
      |=> in_run && flag_out)
      else $error("timer end did not release halt");

   a_stop_cleared: assert property (@(posedge clk_in) disable iff (!rst_n)
      osc_stop_out |=> (tw_rdata_out == 10'h000) && !running_r)
      else $error("timer not cleared in stop");

   a_pulldown_off: assert property (@(posedge clk_in) disable iff (!rst_n)
      (ind_mode |-> !pulldown_out.sense_indicator_pd) and
      (!sense_in_mode |-> !pulldown_out.sense_input_pd))
      else $error("pull-down left on in output or off mode");

   a_halt_early: assert property (@(posedge clk_in) disable iff (!rst_n)
      halt_take && rel_req && !flag_r |=> in_run && flag_out)
      else $error("standby entered with release already true");

endmodule : ir_remote_timer_standby

// ---- ir_timer_pkg.sv ----
// constants and types of the remote-control transmission timer
package ir_timer_pkg;

   // ==================================================================
   // pin mode register
   localparam logic [7:0] PIN_MODE_RST   = 8'h26;
   localparam logic [7:0] PIN_MODE_WMASK = 8'h37;
   localparam int         PM_SENSE_IN    = 0;
   localparam int         PM_KEY_DIR     = 1;
   localparam int         PM_IND_MODE    = 2;
   localparam int         PM_SENSE_PD    = 4;
   localparam int         PM_KEY_PD      = 5;

   // ==================================================================
   // timing, in oscillator periods
   localparam logic [6:0] TICK_LAST_BASE = 7'h3F;  // 64 periods
   localparam logic [6:0] TICK_LAST_HALF = 7'h7F;  // 128 periods
   localparam logic [7:0] CAR_PER_FAST   = 8'h08;
   localparam logic [7:0] CAR_PER_MID    = 8'h40;
   localparam logic [7:0] CAR_PER_SLOW   = 8'h60;
   localparam logic [7:0] CAR_HI_THIRD   = 8'h20;

   // ==================================================================
   // halt operand codes (low three bits)
   localparam logic [2:0] HALT_TIMER_OP  = 3'h5;
   localparam logic [2:0] STOP_ALL_OP    = 3'h0;
   localparam logic [2:0] STOP_ALT_OP    = 3'h3;
   localparam logic [2:0] STOP_ONE_OP    = 3'h6;

   typedef enum logic [1:0] {
      ST_RUN  = 2'b00,
      ST_HALT = 2'b01,
      ST_STOP = 2'b10
   } standby_t;

   typedef struct packed {
      logic       clock_halver;
      logic       carrier_gate;
      logic       carrier_sel_high;
      logic       carrier_sel_low;
   } carrier_cfg_t;

   typedef struct packed {
      logic       sense_input_pd;
      logic       sense_indicator_pd;
      logic       key_in_port_pd;
   } pulldown_t;

endpackage : ir_timer_pkg

// ---- testbench.sv ----
// self-checking bench for the remote transmission timer block
`timescale 1ns/10ps
module testbench;
   // ==================================================================
   // signals
   logic clk_in = 1'b0, arst_n_in = 1'b0, pm_wr_in = 1'b0, tw_wr_in = 1'b0;
   logic halt_in = 1'b0, flag_clr_in = 1'b0, flag_out, timer_end_out;
   logic [7:0] pm_wdata_in = 8'h00, pm_rdata_out;
   logic [9:0] tw_wdata_in = 10'h000, tw_rdata_out;
   ir_timer_pkg::carrier_cfg_t car_cfg_in = 4'h4;
   logic [3:0] halt_op_in = 4'h0, key_in_port_in, press = 4'h0;
   logic sense_input_in, sense_ind_in, sense_ind_out, sense_ind_oe_out;
   logic sense_in_en_out, key_scan_oe_out, ir_drive_pin_out;
   logic cpu_halt_out, osc_stop_out;
   ir_timer_pkg::pulldown_t pulldown_out;
   int errors = 0, tests_run = 0;

   always #2 clk_in = ~clk_in;

   ir_remote_timer_standby u_ir_remote_timer_standby (.clk_in, .arst_n_in,
      .pm_wr_in, .pm_wdata_in, .pm_rdata_out, .tw_wr_in, .tw_wdata_in,
      .tw_rdata_out, .car_cfg_in, .halt_in, .halt_op_in, .flag_clr_in,
      .flag_out, .key_in_port_in, .sense_input_in, .sense_ind_in,
      .sense_ind_out, .sense_ind_oe_out, .sense_in_en_out, .key_scan_oe_out,
      .pulldown_out, .ir_drive_pin_out, .timer_end_out, .cpu_halt_out,
      .osc_stop_out);

   ir_key_led_model u_ir_key_led_model (.clk_in, .press_in(press),
      .pd_in(pulldown_out), .ind_drv_in(sense_ind_out),
      .ind_oe_in(sense_ind_oe_out), .key_in_port_out(key_in_port_in),
      .sense_input_out(sense_input_in), .sense_ind_out(sense_ind_in));

   // ==================================================================
   // helpers
   task check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task stop_test;
      $display("checks=%0d errors=%0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : stop_test

   task clk1;
      @(posedge clk_in);
      #1;
   endtask : clk1

   task pm_wr(input logic [7:0] d);
      @(posedge clk_in);
      pm_wr_in <= 1'b1;
      pm_wdata_in <= d;
      @(posedge clk_in);
      pm_wr_in <= 1'b0;
   endtask : pm_wr

   task tw_wr(input logic [9:0] d);
      @(posedge clk_in);
      tw_wr_in <= 1'b1;
      tw_wdata_in <= d;
      @(posedge clk_in);
      tw_wr_in <= 1'b0;
   endtask : tw_wr

   task pulse(input logic hlt, input logic [3:0] op);
      @(posedge clk_in);
      halt_in <= hlt;
      flag_clr_in <= ~hlt;
      halt_op_in <= op;
      @(posedge clk_in);
      halt_in <= 1'b0;
      flag_clr_in <= 1'b0;
   endtask : pulse

   function logic sig(input int w);
      case (w)
         0: return ir_drive_pin_out;
         1: return cpu_halt_out;
         2: return osc_stop_out;
         default: return timer_end_out;
      endcase
   endfunction : sig

   task automatic wait_sig(input int w, input logic v, input int lim);
      int n;
      n = 0;
      while (sig(w) !== v && n < lim) begin
         clk1;
         n++;
      end
      if (n >= lim) check(16'(sig(w)), 16'(v));
   endtask : wait_sig

   task automatic run_len(input int w, input logic v, output int n);
      n = 0;
      while (sig(w) === v && n < 5000) begin
         clk1;
         n++;
      end
   endtask : run_len

   task automatic timed(input int n, input logic h);
      int c;
      @(posedge clk_in);
      car_cfg_in <= {h, 3'b100};
      tw_wr({1'b1, n[8:0]});
      repeat (3) clk1;
      check({ir_drive_pin_out, sense_ind_out}, 2'b10);
      run_len(3, 1'b0, c);
      check(16'(c + 3), 16'((n + 1) * (h ? 128 : 64)));
      repeat (2) clk1;
      check({ir_drive_pin_out, sense_ind_out}, 2'b01);
      check(tw_rdata_out[8:0], 9'h000);
   endtask : timed

   task automatic carrier(input int s, input logic h);
      int hi, lo;
      int per[4] = '{8, 64, 96, 96};
      int hw[4] = '{4, 32, 48, 32};
      @(posedge clk_in);
      car_cfg_in <= {h, 1'b0, 2'(s)};
      tw_wr(10'h214);
      wait_sig(0, 1'b1, 300);
      wait_sig(0, 1'b0, 300);
      wait_sig(0, 1'b1, 300);
      run_len(0, 1'b1, hi);
      run_len(0, 1'b0, lo);
      check(16'(hi), 16'(hw[s] << h));
      check(16'(hi + lo), 16'(per[s] << h));
      tw_wr(10'h000);
      wait_sig(0, 1'b0, 100);
   endtask : carrier

   // ==================================================================
   // main sequence
   initial begin
      int v, hi;
      logic [7:0] m;
      logic [2:0] ops[3] = '{3'h0, 3'h3, 3'h6};
      v = $urandom(32'hD4C5796A);
      repeat (8) @(posedge clk_in);
      arst_n_in <= 1'b1;
      repeat (3) clk1;
      check(pm_rdata_out, 8'h26);
      check({key_scan_oe_out, sense_ind_oe_out, sense_in_en_out,
             pulldown_out}, 6'h31);
      check({tw_rdata_out, timer_end_out, ir_drive_pin_out, sense_ind_out,
             flag_out}, 14'h00A);
      for (int i = 0; i < 8; i++) begin
         m = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
         pm_wr(m);
         clk1;
         check(pm_rdata_out, m & 8'h37);
         check({key_scan_oe_out, sense_ind_oe_out, sense_in_en_out},
               {m[1], m[2], m[0]});
         check(pulldown_out, {m[4] & m[0], m[4] & ~m[2], m[5]});
      end
      tw_wr(10'h200);
      repeat (2) clk1;
      check(timer_end_out, 1'b1);
      for (int i = 0; i < 4; i++)
         timed((i == 0) ? 1 : 1 + int'($urandom % 12), i[0]);
      // write 256 then 0 one instruction later: 64-clock drive pulse
      tw_wr(10'h300);
      hi = 0;
      for (int k = 1; k <= 80; k++) begin
         @(posedge clk_in);
         tw_wr_in <= (k == 63);
         tw_wdata_in <= 10'h000;
         #1;
         hi += int'(ir_drive_pin_out);
      end
      check(16'(hi), 16'd64);
      for (int i = 0; i < 8; i++)
         carrier(i % 4, i / 4);
      @(posedge clk_in);
      car_cfg_in <= 4'h4;
      tw_wr(10'h205);
      pulse(1'b0, 4'h0);
      pulse(1'b1, 4'h5);
      clk1;
      check({cpu_halt_out, ir_drive_pin_out, sense_ind_out}, 3'b110);
      wait_sig(1, 1'b0, 800);
      check({timer_end_out, flag_out}, 2'b11);
      pulse(1'b0, 4'h0);
      pulse(1'b1, 4'h5);
      clk1;
      check({cpu_halt_out, flag_out}, 2'b01);
      for (int i = 0; i < 3; i++) begin
         m = 8'h26 | (8'($urandom) & 8'h11);
         pm_wr(m);
         tw_wr(10'h3FF);
         pulse(1'b0, 4'h0);
         pulse(1'b1, {1'b0, ops[i]});
         clk1;
         check({osc_stop_out, cpu_halt_out}, 2'b11);
         clk1;
         check(tw_rdata_out, 10'h000);
         check(pm_rdata_out, m & 8'h37);
         @(posedge clk_in);
         press <= 4'h1 << i;
         wait_sig(2, 1'b0, 10);
         check({cpu_halt_out, flag_out}, 2'b01);
         @(posedge clk_in);
         press <= 4'h0;
      end
      stop_test();
   end

   // watchdog sized well above the longest expected run
   initial begin
      #200000;
      errors++;
      stop_test();
   end
endmodule : testbench
